// file: hdl/three_phase_output_buffer.sv
// Three-phase PWM output stage with phase buffers, dead time and forced cutoff.
`timescale 1ns/100ps
`include "three_phase_consts.svh"

module three_phase_output_buffer
	import three_phase_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [11:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        emergencyN,
	output phase_bits_t      phaseOut,
	output phase_bits_t      phaseOutEnN
);

	// ----------------------------------------------------------------------
	// Declarations.
	// ----------------------------------------------------------------------
	logic         threePhaseEnable_reg;
	logic         emergencyCutoffEnable_reg;
	logic [15:0]  carrierTop_reg;
	logic [7:0]   deadTime_reg;
	logic [15:0]  phaseCompare_reg [3];
	phase_bits_t  phaseBufferFirst_reg;
	phase_bits_t  phaseBufferSecond_reg;
	phase_bits_t  shiftReg;
	logic [15:0]  carrierCnt;
	carrier_dir_e carrierDir;
	logic         carrierPeak;
	logic         carrierValley;
	logic         emerMeta;
	logic         emerSync;
	logic         cutoffActive_reg;
	logic [2:0]   rawOn;
	logic [2:0]   hiOn;
	logic [2:0]   loOn;
	logic [9:0]   wordIdx;
	logic         busAccept;
	logic         wrLow;
	logic [31:0]  readValue;

	// ----------------------------------------------------------------------
	// Avalon-MM slave.
	// ----------------------------------------------------------------------

	// The word index drops the byte offset; only byte enable 0 gates a write.
	assign wordIdx   = avs_address[11:2];
	assign busAccept = (avs_read || avs_write) && !avs_waitrequest;
	assign wrLow     = avs_write && !avs_waitrequest && avs_byteenable[0];

	// Every access waits exactly one cycle, so read data can be registered.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// Read mux; unmapped words and reserved bits read as zero.
	always_comb begin
		readValue = 32'h0000_0000;
		case (wordIdx)
			`IDX_INV_CONTROL: begin
				readValue[`BIT_PHASE_ENABLE]  = threePhaseEnable_reg;
				readValue[`BIT_CUTOFF_ENABLE] = emergencyCutoffEnable_reg;
			end
			`IDX_CARRIER_TOP: readValue[15:0] = carrierTop_reg;
			`IDX_DEAD_TIME:   readValue[7:0]  = deadTime_reg;
			`IDX_COMPARE_U:   readValue[15:0] = phaseCompare_reg[0];
			`IDX_COMPARE_V:   readValue[15:0] = phaseCompare_reg[1];
			`IDX_COMPARE_W:   readValue[15:0] = phaseCompare_reg[2];
			`IDX_STATUS: begin
				readValue[`BIT_CUTOFF_ACTIVE] = cutoffActive_reg;
				readValue[`BIT_EMER_LEVEL]    = emerSync;
				readValue[`BIT_CARRIER_DOWN]  = (carrierDir == CARRIER_DOWN);
			end
			`IDX_BUF_FIRST:  readValue[5:0] = shiftReg;
			`IDX_BUF_SECOND: readValue[5:0] = shiftReg;
			default:         readValue = 32'h0000_0000;
		endcase
	end

	// Read data is caught at the edge that drops waitrequest and held after.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= readValue;
		end
	end

	// Control and timing registers; a write lands when waitrequest is low.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			threePhaseEnable_reg      <= 1'b0;
			emergencyCutoffEnable_reg <= 1'b0;
			carrierTop_reg            <= `RST_COUNT16;
			deadTime_reg              <= `RST_DEAD;
			phaseCompare_reg[0]       <= `RST_COUNT16;
			phaseCompare_reg[1]       <= `RST_COUNT16;
			phaseCompare_reg[2]       <= `RST_COUNT16;
		end else if (wrLow) begin
			case (wordIdx)
				`IDX_INV_CONTROL: begin
					threePhaseEnable_reg      <= avs_writedata[`BIT_PHASE_ENABLE];
					emergencyCutoffEnable_reg <= avs_writedata[`BIT_CUTOFF_ENABLE];
				end
				`IDX_CARRIER_TOP: carrierTop_reg      <= avs_writedata[15:0];
				`IDX_DEAD_TIME:   deadTime_reg        <= avs_writedata[7:0];
				`IDX_COMPARE_U:   phaseCompare_reg[0] <= avs_writedata[15:0];
				`IDX_COMPARE_V:   phaseCompare_reg[1] <= avs_writedata[15:0];
				`IDX_COMPARE_W:   phaseCompare_reg[2] <= avs_writedata[15:0];
				default: begin
				end
			endcase
		end
	end

	// Phase buffers: each bit picks active (0) or inactive (1) level.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phaseBufferFirst_reg  <= `RST_BUFFER;
			phaseBufferSecond_reg <= `RST_BUFFER;
		end else if (wrLow && wordIdx == `IDX_BUF_FIRST) begin
			phaseBufferFirst_reg  <= avs_writedata[5:0];
		end else if (wrLow && wordIdx == `IDX_BUF_SECOND) begin
			phaseBufferSecond_reg <= avs_writedata[5:0];
		end
	end

	// ----------------------------------------------------------------------
	// Carrier timer.
	// ----------------------------------------------------------------------

	// The turning points decide when the shift register takes a new buffer.
	assign carrierPeak   = (carrierDir == CARRIER_UP) && (carrierCnt >= carrierTop_reg);
	assign carrierValley = (carrierDir == CARRIER_DOWN) && (carrierCnt == `RST_COUNT16);

	// Triangular count between zero and the top; parked at zero when off.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			carrierCnt <= `RST_COUNT16;
			carrierDir <= CARRIER_UP;
		end else if (!threePhaseEnable_reg) begin
			carrierCnt <= `RST_COUNT16;
			carrierDir <= CARRIER_UP;
		end else begin
			case (carrierDir)
				CARRIER_UP: begin
					if (carrierPeak) begin
						carrierDir <= CARRIER_DOWN;
						if (carrierCnt != `RST_COUNT16) begin
							carrierCnt <= carrierCnt - 16'h0001;
						end
					end else begin
						carrierCnt <= carrierCnt + 16'h0001;
					end
				end
				CARRIER_DOWN: begin
					if (carrierValley) begin
						carrierDir <= CARRIER_UP;
						if (carrierTop_reg != `RST_COUNT16) begin
							carrierCnt <= carrierCnt + 16'h0001;
						end
					end else begin
						carrierCnt <= carrierCnt - 16'h0001;
					end
				end
				default: carrierDir <= CARRIER_UP;
			endcase
		end
	end

	// Three-phase shift register: first buffer at the valley, second at the peak.
	// Loading only at turning points keeps a buffer write from cutting a pulse.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			shiftReg <= `RST_BUFFER;
		end else if (!threePhaseEnable_reg || carrierValley) begin
			shiftReg <= phaseBufferFirst_reg;
		end else if (carrierPeak) begin
			shiftReg <= phaseBufferSecond_reg;
		end
	end

	// ----------------------------------------------------------------------
	// Phase timers and dead-time timers, one of each per phase.
	// ----------------------------------------------------------------------
	for (genvar p = 0; p < 3; p++) begin : g_phase
		logic [7:0] deadCnt;
		logic       prevRaw;

		// The phase timer turns its high side on while compare exceeds carrier.
		assign rawOn[p] = (phaseCompare_reg[p] > carrierCnt);

		// The dead-time timer restarts on every edge of the raw phase.
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				deadCnt <= `RST_DEAD;
				prevRaw <= 1'b0;
			end else if (rawOn[p] != prevRaw) begin
				prevRaw <= rawOn[p];
				deadCnt <= deadTime_reg;
			end else if (deadCnt != `RST_DEAD) begin
				deadCnt <= deadCnt - 8'h01;
			end
		end

		// Both sides stay off until the dead time has run out.
		assign hiOn[p] = prevRaw && (rawOn[p] == prevRaw) && (deadCnt == `RST_DEAD);
		assign loOn[p] = !prevRaw && (rawOn[p] == prevRaw) && (deadCnt == `RST_DEAD);
	end

	// ----------------------------------------------------------------------
	// Emergency input and forced cutoff.
	// ----------------------------------------------------------------------

	// Two-stage synchroniser for the asynchronous emergency pin.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			emerMeta <= 1'b1;
			emerSync <= 1'b1;
		end else begin
			emerMeta <= emergencyN;
			emerSync <= emerMeta;
		end
	end

	// Cutoff latches while enabled and the pin is low; both conditions release it.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cutoffActive_reg <= 1'b0;
		end else if (emergencyCutoffEnable_reg && !emerSync) begin
			cutoffActive_reg <= 1'b1;
		end else if (!emergencyCutoffEnable_reg && emerSync) begin
			cutoffActive_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------------
	// Output pins.
	// ----------------------------------------------------------------------

	// Active level is high; pins are released when off or cut off.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phaseOut    <= `RST_BUFFER;
			phaseOutEnN <= `ALL_RELEASED;
		end else if (!threePhaseEnable_reg || cutoffActive_reg) begin
			phaseOut    <= `RST_BUFFER;
			phaseOutEnN <= `ALL_RELEASED;
		end else begin
			for (int i = 0; i < 3; i++) begin
				phaseOut[2*i]   <= hiOn[i] && !shiftReg[2*i];
				phaseOut[2*i+1] <= loOn[i] && !shiftReg[2*i+1];
			end
			phaseOutEnN <= `RST_BUFFER;
		end
	end

	// ----------------------------------------------------------------------
	// Assertions and covers.
	// ----------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_enable_gate: assert property (
		!threePhaseEnable_reg |=> phaseOutEnN == `ALL_RELEASED && carrierCnt == `RST_COUNT16)
		else $error("outputs or carrier active while disabled");

	a_carrier_turn: assert property (
		threePhaseEnable_reg && carrierPeak && carrierTop_reg != `RST_COUNT16
		|=> carrierDir == CARRIER_DOWN)
		else $error("carrier did not turn at its top");

	a_no_overlap: assert property (
		!(phaseOut[0] && phaseOut[1]) && !(phaseOut[2] && phaseOut[3])
		&& !(phaseOut[4] && phaseOut[5]))
		else $error("output and complement both active");

	a_dead_gap: assert property (
		$fell(phaseOut[1]) && deadTime_reg >= 8'h02 |-> !phaseOut[0] ##1 !phaseOut[0])
		else $error("dead time not kept after complement fell");

	a_buffer_write: assert property (
		wrLow && wordIdx == `IDX_BUF_FIRST |=> phaseBufferFirst_reg == $past(avs_writedata[5:0]))
		else $error("first phase buffer not written");

	a_read_shift: assert property (
		avs_read && !avs_waitrequest && wordIdx == `IDX_BUF_SECOND
		|-> avs_readdata == {26'h000_0000, $past(shiftReg)})
		else $error("phase buffer read is not the shift register");

	a_cutoff_hiz: assert property (
		cutoffActive_reg |=> phaseOutEnN == `ALL_RELEASED && phaseOut == `RST_BUFFER)
		else $error("pins driven during cutoff");

	a_cutoff_hold: assert property (
		cutoffActive_reg && emergencyCutoffEnable_reg |=> cutoffActive_reg)
		else $error("cutoff released while still enabled");

	a_cutoff_release: assert property (
		cutoffActive_reg && !emergencyCutoffEnable_reg && emerSync |=> !cutoffActive_reg)
		else $error("cutoff not released");

	a_cutoff_entry: assert property (
		!emergencyCutoffEnable_reg && !cutoffActive_reg |=> !cutoffActive_reg)
		else $error("cutoff entered while disabled");

	a_bus_answer: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");

	c_cutoff_entered: cover property ($rose(cutoffActive_reg));
	c_buffer_read: cover property (busAccept && avs_read && wordIdx == `IDX_BUF_FIRST);
	c_u_pulse: cover property ($rose(phaseOut[0]) ##[1:50] $rose(phaseOut[1]));
	c_shift_second: cover property (threePhaseEnable_reg && carrierPeak);

endmodule : three_phase_output_buffer

// file: hdl/three_phase_consts.svh
// Offsets, field positions and reset values of the three-phase output buffer.
`ifndef THREE_PHASE_CONSTS_SVH
`define THREE_PHASE_CONSTS_SVH

// ----------------------------------------------------------------------
// Register word indexes; byte address is four times the index.
// ----------------------------------------------------------------------
`define IDX_INV_CONTROL   10'h340
`define IDX_CARRIER_TOP   10'h341
`define IDX_DEAD_TIME     10'h342
`define IDX_COMPARE_U     10'h343
`define IDX_COMPARE_V     10'h344
`define IDX_COMPARE_W     10'h345
`define IDX_STATUS        10'h346
`define IDX_BUF_FIRST     10'h34A
`define IDX_BUF_SECOND    10'h34B

// ----------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------
`define BIT_PHASE_ENABLE  0
`define BIT_CUTOFF_ENABLE 1
`define BIT_CUTOFF_ACTIVE 0
`define BIT_EMER_LEVEL    1
`define BIT_CARRIER_DOWN  2
`define RST_BUFFER        6'h00
`define RST_COUNT16       16'h0000
`define RST_DEAD          8'h00
`define ALL_RELEASED      6'h3F

`endif

// file: hdl/three_phase_pkg.sv
// Types shared by the three-phase output buffer.
package three_phase_pkg;

	// Direction of the triangular carrier count.
	typedef enum logic {
		CARRIER_UP,
		CARRIER_DOWN
	} carrier_dir_e;

	// One bit per output: U, U-complement, V, V-complement, W, W-complement.
	typedef logic [5:0] phase_bits_t;

endpackage : three_phase_pkg

// file: bench/gate_driver_model.sv
// Behavioural gate-driver stage that watches the six phase outputs.
`timescale 1ns/100ps

module gate_driver_model
	import three_phase_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        clear,
	input  wire logic        faultReq,
	input  wire phase_bits_t phaseOut,
	input  wire phase_bits_t phaseOutEnN,
	output logic             emergencyN,
	output phase_bits_t      seenOn,
	output int               shootCount
);
	// ----------------------------------------------------------------
	// Fault reporting
	// ----------------------------------------------------------------
	// The fault line has a pull-up, so a released line reads high.
	assign emergencyN = faultReq ? 1'b0 : 1'b1;

	// ----------------------------------------------------------------
	// Gate monitoring
	// ----------------------------------------------------------------
	// Both gates of one leg on together would short the supply rail.
	always_ff @(posedge clk) begin
		if (clear) begin
			seenOn <= '0;
			shootCount <= 0;
		end else begin
			seenOn <= seenOn | (phaseOut & ~phaseOutEnN);
			if (|(phaseOut[4:0] & phaseOut[5:1] & 5'b1_0101)) begin
				shootCount <= shootCount + 1;
			end
		end
	end
endmodule : gate_driver_model

// file: bench/testbench.sv
// Self-checking bench for the three-phase output buffer.
`timescale 1ns/100ps
`include "three_phase_consts.svh"

`define CHECK(got, exp, msg) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) begin \
			n_mismatch++; \
			$display("mismatch at %0t: %s", $time, msg); \
		end \
	end

module testbench
	import three_phase_pkg::*;
;
	logic        clk;
	logic        resetn;
	logic [11:0] avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        emergencyN;
	phase_bits_t phaseOut;
	phase_bits_t phaseOutEnN;
	phase_bits_t seenOn;
	logic        clear;
	logic        faultReq;
	int          shootCount;
	int          n_mismatch;
	int          cmp_count;

	three_phase_output_buffer dut_u (
		.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .emergencyN(emergencyN),
		.phaseOut(phaseOut), .phaseOutEnN(phaseOutEnN)
	);

	gate_driver_model drv_u (
		.clk(clk), .clear(clear), .faultReq(faultReq), .phaseOut(phaseOut),
		.phaseOutEnN(phaseOutEnN), .emergencyN(emergencyN), .seenOn(seenOn),
		.shootCount(shootCount)
	);

	// ----------------------------------------------------------------
	// Bus and helper tasks
	// ----------------------------------------------------------------
	// The clock toggles every 4 ns, half of its 8 ns period.
	always #4 clk = ~clk;

	task automatic complete_run();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run

	// One Avalon transfer; the first edge keeps it clear of a previous release.
	task automatic busOp(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
			output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// A bound used up without an answer is a mismatch and ends the run.
		if (avs_waitrequest !== 1'b0) begin
			n_mismatch++;
			complete_run();
		end
	endtask : busOp

	task automatic regWrite(input logic [9:0] idx, input logic [31:0] wd);
		logic [31:0] rd;
		busOp(1'b1, idx, wd, rd);
	endtask : regWrite

	task automatic regCheck(input logic [9:0] idx, input logic [5:0] exp);
		logic [31:0] rd;
		busOp(1'b0, idx, 32'h0000_0000, rd);
		`CHECK(rd, {26'h000_0000, exp}, "register read")
	endtask : regCheck

	// A bounded wait for the output enables to reach a value.
	task automatic waitEnN(input phase_bits_t exp, input int bound);
		int n;
		for (n = 0; n < bound && phaseOutEnN !== exp; n++) begin
			@(posedge clk);
		end
		`CHECK(phaseOutEnN, exp, "output enables")
		if (phaseOutEnN !== exp) begin
			complete_run();
		end
	endtask : waitEnN

	task automatic idleClear(input int cycles);
		repeat (cycles) @(posedge clk);
		clear <= 1'b1;
		@(posedge clk);
		clear <= 1'b0;
		repeat (40) @(posedge clk);
	endtask : idleClear

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic checkResetAndRefusals();
		regCheck(`IDX_INV_CONTROL, 6'h00);
		regCheck(`IDX_BUF_FIRST, 6'h00);
		regCheck(`IDX_BUF_SECOND, 6'h00);
		`CHECK(phaseOutEnN, 6'h3F, "pins released after reset")
		regWrite(10'h3FF, 32'h0000_0003);
		regCheck(10'h3FF, 6'h00);
		avs_byteenable <= 4'h0;
		regWrite(`IDX_INV_CONTROL, 32'h0000_0001);
		avs_byteenable <= 4'hF;
		regCheck(`IDX_INV_CONTROL, 6'h00);
	endtask : checkResetAndRefusals

	// While disabled the shift register follows the first buffer, not the last write.
	task automatic checkBufferRead();
		regWrite(`IDX_BUF_FIRST, 32'h0000_0015);
		regCheck(`IDX_BUF_SECOND, 6'h15);
		regWrite(`IDX_BUF_SECOND, 32'h0000_002A);
		regCheck(`IDX_BUF_SECOND, 6'h15);
		regCheck(`IDX_BUF_FIRST, 6'h15);
		`CHECK(phaseOutEnN, 6'h3F, "pins driven while disabled")
	endtask : checkBufferRead

	task automatic checkPwm();
		// A dead time of two leaves both sides of every leg room to switch on.
		regWrite(`IDX_CARRIER_TOP, 32'h0000_0008);
		regWrite(`IDX_DEAD_TIME, 32'h0000_0002);
		regWrite(`IDX_COMPARE_U, 32'h0000_0004);
		regWrite(`IDX_COMPARE_V, 32'h0000_0004);
		regWrite(`IDX_COMPARE_W, 32'h0000_0004);
		regWrite(`IDX_BUF_FIRST, 32'h0000_003F);
		regWrite(`IDX_BUF_SECOND, 32'h0000_003F);
		regWrite(`IDX_INV_CONTROL, 32'h0000_0001);
		waitEnN(6'h00, 20);
		idleClear(10);
		`CHECK(seenOn, 6'h00, "inactive buffers drove a gate")
		regWrite(`IDX_BUF_FIRST, 32'h0000_0000);
		regWrite(`IDX_BUF_SECOND, 32'h0000_0000);
		idleClear(10);
		`CHECK(seenOn, 6'h3F, "not every output switched")
		`CHECK(shootCount, 0, "leg gates overlapped")
	endtask : checkPwm

	task automatic checkCutoff();
		logic [31:0] rd;
		faultReq <= 1'b1;
		repeat (10) @(posedge clk);
		`CHECK(phaseOutEnN, 6'h00, "cutoff while disabled by software")
		faultReq <= 1'b0;
		regWrite(`IDX_INV_CONTROL, 32'h0000_0003);
		faultReq <= 1'b1;
		waitEnN(6'h3F, 10);
		// The carrier keeps running under cutoff, so its direction bit is not judged here.
		busOp(1'b0, `IDX_STATUS, 32'h0000_0000, rd);
		`CHECK(rd[1:0], 2'b01, "cutoff status")
		faultReq <= 1'b0;
		repeat (10) @(posedge clk);
		`CHECK(phaseOutEnN, 6'h3F, "released with enable still set")
		regWrite(`IDX_INV_CONTROL, 32'h0000_0001);
		waitEnN(6'h00, 10);
		regWrite(`IDX_INV_CONTROL, 32'h0000_0000);
		waitEnN(6'h3F, 10);
		regCheck(`IDX_STATUS, 6'h02);
	endtask : checkCutoff

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		avs_address = 12'h000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hF;
		clear = 1'b1;
		faultReq = 1'b0;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		clear <= 1'b0;
		checkResetAndRefusals();
		checkBufferRead();
		checkPwm();
		checkCutoff();
		complete_run();
	end
endmodule : testbench
